// ### hw/fsf_pkg.sv
// Constants for the fault status and flag logic
`default_nettype none
package fsf_pkg;
  // ==========================================
  // Status byte bit positions
  localparam int STAT_CONV_SEEN = 0;
  localparam int STAT_CONV_TRIP = 1;
  localparam int STAT_COMP_NOW = 2;
  localparam int STAT_COMP_TRIP = 3;
  localparam int STAT_OFF_STATUS = 4;
  localparam int STAT_OFF_TRIP = 5;
  // ==========================================
  // Command byte layout and extended register selects
  localparam int CMD_EXT_BIT = 7;
  localparam int CMD_STATUS_SEL_BIT = 6;
  localparam logic [1:0] EXT_FAULT_EN = 2'h1;
  localparam logic [1:0] EXT_THRESH = 2'h2;
  localparam logic [1:0] EXT_CONTROL = 2'h3;
  // ==========================================
  // Fault enable and control register fields, fault enable reset value
  localparam int EN_CONV_SINGLE = 0;
  localparam int EN_CONV_FOUR = 1;
  localparam int EN_COMP_FAULT = 2;
  localparam int EN_OFF_FAULT = 3;
  localparam int EN_CLEAR = 4;
  localparam logic [4:0] EN_RESET = 5'h04;
  localparam int CTRL_SOFT_OFF = 0;
  // ==========================================
  // Defaults
  localparam logic [6:0] DEV_ADDR_DEFAULT = 7'h2a; // Arbitrary address
  localparam int FAULT_DELAY_CYCLES = 2000;
  localparam int CONV_RUN_SEEN = 3;

  typedef enum logic [2:0] {
    FSF_IDLE = 3'b000,
    FSF_ADDR = 3'b001,
    FSF_ADDR_ACK = 3'b010,
    FSF_WR_BYTE = 3'b011,
    FSF_WR_ACK = 3'b100,
    FSF_RD_BYTE = 3'b101,
    FSF_RD_ACK = 3'b110,
    FSF_WAIT_STOP = 3'b111
  } fsf_state_t;
endpackage
`default_nettype wire

// ### hw/fsf_timer_if.sv
// Link between the slave logic and the fault delay timer
`default_nettype none
interface fsf_timer_if;
  logic comp_now;
  logic delay_done;
  modport timer (input comp_now, output delay_done);
  modport ctrl (output comp_now, input delay_done);
endinterface
`default_nettype wire

// ### hw/fsf_fault_timer.sv
// Fault delay timer standing in for the timing capacitor
`default_nettype none
module fsf_fault_timer
  import fsf_pkg::*;
#(
  parameter int DELAY_CYCLES = FAULT_DELAY_CYCLES
) (
  input wire logic mclk_in,
  input wire logic sys_rst_in,
  fsf_timer_if.timer tif
);
  localparam int CW = $clog2(DELAY_CYCLES + 1);
  localparam logic [CW-1:0] DELAY_END = CW'(DELAY_CYCLES);

  logic [CW-1:0] count;
  logic [CW-1:0] next_count;

  // ==========================================
  // Charge while the comparator holds, restart when it drops
  always_comb begin
    if (!tif.comp_now) begin
      next_count = '0;
    end else if (count == DELAY_END) begin
      next_count = count;
    end else begin
      next_count = count + CW'(1);
    end
  end

  always_ff @(posedge mclk_in) begin
    if (sys_rst_in) begin
      count <= '0;
    end else begin
      count <= next_count;
    end
  end

  assign tif.delay_done = tif.comp_now && (count == DELAY_END);
endmodule // fsf_fault_timer
`default_nettype wire

// ### hw/fsf_status_top.sv
// Two-wire slave, status byte and fault output logic
`default_nettype none
module fsf_status_top
  import fsf_pkg::*;
#(
  parameter logic [6:0] DEV_ADDR = DEV_ADDR_DEFAULT,
  parameter int DELAY_CYCLES = FAULT_DELAY_CYCLES
) (
  input wire logic mclk_in,
  input wire logic sys_rst_in,
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe_out,
  input wire logic comparator_overcurrent_now_in,
  input wire logic conv_done_in,
  input wire logic conv_over_in,
  output logic fault_out,
  output logic fault_oe_out,
  output logic [7:0] fault_status_byte_out
);
  fsf_timer_if tif ();

  fsf_fault_timer #(
    .DELAY_CYCLES(DELAY_CYCLES)
  ) u_timer (
    .mclk_in(mclk_in),
    .sys_rst_in(sys_rst_in),
    .tif(tif)
  );

  // ==========================================
  // Pin synchronisers
  logic scl_meta, scl_s, scl_d, sda_meta, sda_s, sda_d, comp_meta, comp_s;
  always_ff @(posedge mclk_in) begin
    if (sys_rst_in) begin
      scl_meta <= 1'b1;
      scl_s <= 1'b1;
      scl_d <= 1'b1;
      sda_meta <= 1'b1;
      sda_s <= 1'b1;
      sda_d <= 1'b1;
      comp_meta <= 1'b0;
      comp_s <= 1'b0;
    end else begin
      scl_meta <= scl_in;
      scl_s <= scl_meta;
      scl_d <= scl_s;
      sda_meta <= sda_in;
      sda_s <= sda_meta;
      sda_d <= sda_s;
      comp_meta <= comparator_overcurrent_now_in;
      comp_s <= comp_meta;
    end
  end
  assign tif.comp_now = comp_s;

  wire scl_rise = scl_s && !scl_d;
  wire scl_fall = !scl_s && scl_d;
  wire bus_start = scl_s && scl_d && sda_d && !sda_s;
  wire bus_stop = scl_s && scl_d && !sda_d && sda_s;

  // ==========================================
  // Slave state
  fsf_state_t state, next_state;
  logic [2:0] bit_cnt, next_bit_cnt;
  logic [7:0] shift, next_shift;
  logic first_byte, next_first_byte;
  logic [1:0] ext_sel, next_ext_sel;
  logic status_mode, next_status_mode;
  logic drive_low, next_drive_low;
  logic [4:0] fault_en, next_fault_en;
  logic soft_shutoff_bit, next_soft_shutoff_bit;
  logic [7:0] stat, next_stat;
  logic [3:0] conv_hist, next_conv_hist;
  logic fault_level, next_fault_level;
  logic wr_done;
  logic [7:0] wr_byte;

  always_comb begin
    next_state = state;
    next_bit_cnt = bit_cnt;
    next_shift = shift;
    next_first_byte = first_byte;
    next_ext_sel = ext_sel;
    next_status_mode = status_mode;
    next_drive_low = drive_low;
    wr_done = 1'b0;
    wr_byte = shift;
    if (bus_start) begin
      next_state = FSF_ADDR;
      next_bit_cnt = 3'h0;
      next_drive_low = 1'b0;
    end else if (bus_stop) begin
      next_state = FSF_IDLE;
      next_drive_low = 1'b0;
    end else begin
      case (state)
        FSF_IDLE, FSF_WAIT_STOP: begin
          next_drive_low = 1'b0;
        end
        FSF_ADDR, FSF_WR_BYTE: begin
          if (scl_rise) begin
            next_shift = {shift[6:0], sda_s};
            next_bit_cnt = bit_cnt + 3'h1;
            if (bit_cnt == 3'h7) begin
              next_state = (state == FSF_ADDR) ? FSF_ADDR_ACK : FSF_WR_ACK;
            end
          end
        end
        FSF_ADDR_ACK: begin
          if (shift[7:1] != DEV_ADDR) begin
            next_state = FSF_WAIT_STOP;
          end else if (scl_fall) begin
            if (!next_drive_low) begin
              next_drive_low = 1'b1;
            end
          end
          if (scl_fall && drive_low) begin
            next_bit_cnt = 3'h0;
            next_first_byte = 1'b1;
            if (shift[0]) begin
              next_state = status_mode ? FSF_RD_BYTE : FSF_WAIT_STOP;
              next_shift = stat;
              next_drive_low = status_mode && !stat[7];
            end else begin
              next_state = FSF_WR_BYTE;
              next_drive_low = 1'b0;
            end
          end
        end
        FSF_WR_ACK: begin
          if (scl_fall && !drive_low) begin
            next_drive_low = 1'b1;
          end else if (scl_fall && drive_low) begin
            next_drive_low = 1'b0;
            next_bit_cnt = 3'h0;
            next_state = FSF_WR_BYTE;
            if (first_byte) begin
              next_first_byte = 1'b0;
              next_ext_sel = shift[1:0];
              if (!shift[CMD_EXT_BIT]) begin
                next_ext_sel = 2'h0;
                next_status_mode = shift[CMD_STATUS_SEL_BIT];
              end
            end else begin
              wr_done = 1'b1;
            end
          end
        end
        FSF_RD_BYTE: begin
          if (scl_fall) begin
            next_bit_cnt = bit_cnt + 3'h1;
            next_shift = {shift[6:0], 1'b1};
            next_drive_low = !shift[6];
            if (bit_cnt == 3'h7) begin
              next_drive_low = 1'b0;
              next_state = FSF_RD_ACK;
            end
          end
        end
        FSF_RD_ACK: begin
          if (scl_rise) begin
            next_state = FSF_WAIT_STOP;
          end
        end
        default: begin
          next_state = FSF_IDLE;
          next_drive_low = 1'b0;
        end
      endcase
    end
  end

  // ==========================================
  // Fault enables, shutoff control and status flags
  wire conv_trip_event = conv_done_in && ((fault_en[EN_CONV_SINGLE] && conv_over_in)
    || (fault_en[EN_CONV_FOUR] && conv_over_in && (&conv_hist[2:0])));
  wire wr_en = wr_done && (ext_sel == EXT_FAULT_EN);
  wire wr_ctrl = wr_done && (ext_sel == EXT_CONTROL);
  wire soft_write = wr_ctrl && wr_byte[CTRL_SOFT_OFF];

  always_comb begin
    next_conv_hist = conv_done_in ? {conv_hist[2:0], conv_over_in} : conv_hist;
    next_fault_en = fault_en;
    next_soft_shutoff_bit = soft_shutoff_bit;
    next_stat = stat;
    if (wr_en) begin
      next_fault_en = wr_byte[4:0];
    end else if (fault_en[EN_CLEAR]) begin
      next_fault_en[EN_CLEAR] = 1'b0;
    end
    if (wr_ctrl) begin
      next_soft_shutoff_bit = wr_byte[CTRL_SOFT_OFF];
    end
    if (fault_en[EN_CLEAR]) begin
      next_stat[STAT_CONV_TRIP] = 1'b0;
      next_stat[STAT_COMP_TRIP] = 1'b0;
      next_stat[STAT_OFF_TRIP] = 1'b0;
    end
    next_stat[STAT_CONV_SEEN] = &next_conv_hist[CONV_RUN_SEEN-1:0];
    next_stat[STAT_COMP_NOW] = comp_s;
    if (conv_trip_event) begin
      next_stat[STAT_CONV_TRIP] = 1'b1;
    end
    if (tif.delay_done && fault_en[EN_COMP_FAULT]) begin
      next_stat[STAT_COMP_TRIP] = 1'b1;
    end
    if (soft_write) begin
      next_stat[STAT_OFF_STATUS] = 1'b1;
    end
    if (soft_write && fault_en[EN_OFF_FAULT]) begin
      next_stat[STAT_OFF_TRIP] = 1'b1;
    end
    next_stat[7:6] = 2'h0;
    next_fault_level = tif.delay_done || next_stat[STAT_CONV_TRIP] || next_stat[STAT_COMP_TRIP]
      || (next_stat[STAT_OFF_TRIP] && next_soft_shutoff_bit && fault_en[EN_OFF_FAULT]);
  end

  always_ff @(posedge mclk_in) begin
    if (sys_rst_in) begin
      state <= FSF_IDLE;
      bit_cnt <= 3'h0;
      shift <= 8'h00;
      first_byte <= 1'b0;
      ext_sel <= 2'h0;
      status_mode <= 1'b1;
      drive_low <= 1'b0;
      fault_en <= EN_RESET;
      soft_shutoff_bit <= 1'b0;
      stat <= 8'h00;
      conv_hist <= 4'h0;
      fault_level <= 1'b0;
      sda_out <= 1'b0;
      sda_oe_out <= 1'b0;
      fault_out <= 1'b0;
      fault_oe_out <= 1'b1;
      fault_status_byte_out <= 8'h00;
    end else begin
      state <= next_state;
      bit_cnt <= next_bit_cnt;
      shift <= next_shift;
      first_byte <= next_first_byte;
      ext_sel <= next_ext_sel;
      status_mode <= next_status_mode;
      drive_low <= next_drive_low;
      fault_en <= next_fault_en;
      soft_shutoff_bit <= next_soft_shutoff_bit;
      stat <= next_stat;
      conv_hist <= next_conv_hist;
      fault_level <= next_fault_level;
      sda_out <= 1'b0;
      sda_oe_out <= next_drive_low;
      fault_out <= 1'b0;
      fault_oe_out <= !next_fault_level;
      fault_status_byte_out <= next_stat;
    end
  end
endmodule // fsf_status_top
`default_nettype wire

// ### testbench/fsf_master_model.sv
// Two-wire bus master model for the status block
`default_nettype none
module fsf_master_model (
  input wire logic mclk_in,
  input wire logic sda_in,
  output logic scl_out,
  output logic sda_low_out
);
  timeunit 1ns;
  timeprecision 1ps;
  // ==========================================
  // Bus phases, data bits move SDA only while SCL is low; start and stop move it while SCL is high
  initial begin
    scl_out = 1'b1;
    sda_low_out = 1'b0;
  end
  task automatic hp;
    repeat (8) @(posedge mclk_in);
  endtask
  task automatic start;
    sda_low_out <= 1'b0;
    scl_out <= 1'b1;
    hp;
    sda_low_out <= 1'b1;
    hp;
    scl_out <= 1'b0;
  endtask
  task automatic stop;
    hp;
    sda_low_out <= 1'b1;
    hp;
    scl_out <= 1'b1;
    hp;
    sda_low_out <= 1'b0;
    hp;
  endtask
  // Eight bits MSB first then the ack slot; a 0 in d[0] is the master ack
  task automatic xfer(input logic [8:0] d, output logic [8:0] q);
    for (int i = 8; i >= 0; i--) begin
      repeat (3) @(posedge mclk_in);
      sda_low_out <= !d[i];
      hp;
      scl_out <= 1'b1;
      hp;
      q[i] = sda_in;
      scl_out <= 1'b0;
    end
  endtask
endmodule // fsf_master_model
`default_nettype wire

// ### testbench/fsf_status_top_assertions.sv
// Port assertions for the fault status and flag logic
`default_nettype none
module fsf_status_top_assertions #(
  parameter int DELAY_CYCLES = 8
) (
  input wire logic mclk_in,
  input wire logic sys_rst_in,
  input wire logic scl_in,
  input wire logic sda_in,
  input wire logic sda_out,
  input wire logic sda_oe_out,
  input wire logic comparator_overcurrent_now_in,
  input wire logic conv_done_in,
  input wire logic conv_over_in,
  input wire logic fault_out,
  input wire logic fault_oe_out,
  input wire logic [7:0] fault_status_byte_out
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (sys_rst_in);
  // ==========================================
  // Comparator run length, saturating past the expected trip point
  int comp_run;
  always_ff @(posedge mclk_in) begin
    if (sys_rst_in || !comparator_overcurrent_now_in) begin
      comp_run <= 0;
    end else if (comp_run < DELAY_CYCLES + 4) begin
      comp_run <= comp_run + 1;
    end
  end
  // ==========================================
  // Properties
  sequence s_comp_held;
    comp_run == DELAY_CYCLES + 4;
  endsequence
  property p_pins_low; !sda_out && !fault_out; endproperty
  property p_reset_low;
    $fell(sys_rst_in) |-> fault_oe_out && !sda_oe_out && (fault_status_byte_out & 8'hfb) == 8'h00;
  endproperty
  property p_comp_on; comparator_overcurrent_now_in [*5] |-> fault_status_byte_out[2]; endproperty
  property p_delay_min;
    ($rose(comparator_overcurrent_now_in) && fault_oe_out) |-> fault_oe_out [*8];
  endproperty
  property p_delay_done; s_comp_held |-> !fault_oe_out; endproperty
  property p_trip_flag;
    (fault_status_byte_out[1] || fault_status_byte_out[3]) |-> ##[0:1] !fault_oe_out;
  endproperty
  property p_clear_group;
    ($fell(fault_status_byte_out[1]) || $fell(fault_status_byte_out[3]) || $fell(fault_status_byte_out[5]))
      |-> (fault_status_byte_out & 8'h2a) == 8'h00;
  endproperty
  property p_off_pair; fault_status_byte_out[5] |-> fault_status_byte_out[4]; endproperty
  a_pins_low: assert property (p_pins_low) else $error("pin driven high");
  a_reset_low: assert property (p_reset_low) else $error("bad state after reset");
  a_comp_on: assert property (p_comp_on) else $error("live comparator bit low");
  a_delay_min: assert property (p_delay_min) else $error("fault before delay");
  a_delay_done: assert property (p_delay_done) else $error("fault missing after delay");
  a_trip_flag: assert property (p_trip_flag) else $error("trip flag without fault");
  a_clear_group: assert property (p_clear_group) else $error("partial clear");
  a_off_pair: assert property (p_off_pair) else $error("off trip without off status");
endmodule // fsf_status_top_assertions
bind fsf_status_top fsf_status_top_assertions #(.DELAY_CYCLES(DELAY_CYCLES)) chk (
  .mclk_in(mclk_in), .sys_rst_in(sys_rst_in), .scl_in(scl_in), .sda_in(sda_in), .sda_out(sda_out),
  .sda_oe_out(sda_oe_out), .comparator_overcurrent_now_in(comparator_overcurrent_now_in),
  .conv_done_in(conv_done_in), .conv_over_in(conv_over_in), .fault_out(fault_out),
  .fault_oe_out(fault_oe_out), .fault_status_byte_out(fault_status_byte_out));
`default_nettype wire

// ### testbench/tb_fsf_status_top.sv
// Testbench for the fault status and flag logic
`default_nettype none
module tb_fsf_status_top;
  import fsf_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int DLY = 8;
  logic mclk_in = 1'b0;
  logic sys_rst_in = 1'b1;
  logic comp = 1'b0;
  logic cdone = 1'b0;
  logic c_over = 1'b0;
  wire logic scl, low, sda_oe, sda_o, f_o, foe;
  wire logic [7:0] stat;
  wire logic sda = !(low || (sda_oe && !sda_o));
  int fail_count = 0;
  int n_checks = 0;
  initial forever #2.5 mclk_in = !mclk_in;
  fsf_master_model m (.mclk_in(mclk_in), .sda_in(sda), .scl_out(scl), .sda_low_out(low));
  fsf_status_top #(.DELAY_CYCLES(DLY)) uut (
    .mclk_in(mclk_in), .sys_rst_in(sys_rst_in), .scl_in(scl), .sda_in(sda), .sda_out(sda_o),
    .sda_oe_out(sda_oe), .comparator_overcurrent_now_in(comp), .conv_done_in(cdone),
    .conv_over_in(c_over), .fault_out(f_o), .fault_oe_out(foe), .fault_status_byte_out(stat));
  // ==========================================
  // Access tasks
  task automatic chk(input string n, input logic [7:0] seen, input logic [7:0] exp);
    n_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("mismatch %s expected %h seen %h", n, exp, seen);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge mclk_in);
  endtask
  task automatic fo(input logic e);
    chk("fault oe", {7'h00, foe}, {7'h00, e});
  endtask
  task automatic rd(input logic [7:0] exp);
    logic [8:0] q;
    m.start;
    m.xfer({DEV_ADDR_DEFAULT, 2'b11}, q);
    chk("addr ack", {7'h00, q[0]}, 8'h00);
    m.xfer(9'h1fe, q);
    m.stop;
    chk("status", q[8:1], exp);
  endtask
  task automatic wr(input logic [7:0] c, input logic [7:0] d);
    logic [8:0] q;
    m.start;
    m.xfer({DEV_ADDR_DEFAULT, 2'b01}, q);
    m.xfer({c, 1'b1}, q);
    m.xfer({d, 1'b1}, q);
    m.stop;
    chk("data ack", {7'h00, q[0]}, 8'h00);
  endtask
  task automatic cv(input logic o);
    cdone <= 1'b1;
    c_over <= o;
    cyc(1);
    cdone <= 1'b0;
    cyc(1);
  endtask
  task automatic test_done;
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  // ==========================================
  // Main sequence
  initial begin
    cyc(4);
    sys_rst_in <= 1'b0;
    cyc(4);
    fo(1'b1);
    rd(8'h00);
    for (int i = 0; i < 5; i++) cv(i != 2);
    cyc(2);
    chk("status", stat, 8'h00);
    cv(1'b1);
    cyc(2);
    chk("status", stat, 8'h01);
    wr(8'h81, 8'h06);
    cv(1'b1);
    cyc(3);
    fo(1'b0);
    rd(8'h03);
    cv(1'b0);
    wr(8'h81, 8'h14);
    rd(8'h00);
    fo(1'b1);
    comp <= 1'b1;
    cyc(DLY / 2);
    comp <= 1'b0;
    cyc(3 * DLY);
    fo(1'b1);
    comp <= 1'b1;
    cyc(6);
    chk("status", stat, 8'h04);
    fo(1'b1);
    cyc(2 * DLY);
    fo(1'b0);
    rd(8'h0c);
    comp <= 1'b0;
    rd(8'h08);
    wr(8'h81, 8'h14);
    rd(8'h00);
    fo(1'b1);
    wr(8'h81, 8'h00);
    comp <= 1'b1;
    cyc(3 * DLY);
    fo(1'b0);
    rd(8'h04);
    comp <= 1'b0;
    cyc(6);
    fo(1'b1);
    wr(8'h83, 8'h01);
    rd(8'h10);
    fo(1'b1);
    wr(8'h81, 8'h1c);
    wr(8'h83, 8'h01);
    rd(8'h30);
    fo(1'b0);
    wr(8'h81, 8'h1c);
    rd(8'h10);
    fo(1'b1);
    wr(8'h82, 8'h00);
    wr(8'h00, 8'h00);
    rd(8'hff);
    wr(8'h40, 8'h00);
    rd(8'h10);
    test_done;
  end
endmodule // tb_fsf_status_top
`default_nettype wire
